//--- hw/wsg_top.sv
// Operation
// - external bus cycles stretch by a programmed count of up to fourteen cycles
// - cycle keeps extending while the ready input stays inactive
// - counter clock gated off when every range programs zero waits
// - low fifteen config bits hold five 3-bit counts, one per range
// - base count multiplied by one, or two when multiplier bit set
// - every 3-bit count resets to seven
// - config bit 15 selects program-space decoding, resets to zero
// - bits 14-12 give I/O space count over 0000-FFFFh
// - bits 11-9 give upper data space count, 8000-FFFFh
// - bits 8-6 give lower data space count, 0000-7FFFh
// - bits 5-3 upper program count: page upper half, or 400000h-7FFFFFh
// - bits 2-0 lower program count: page lower half, or 000000-3FFFFFh
// - control register bits 15-1 read zero; only bit 0 writable, resets zero
`timescale 1ns/1ps
module wsg_top
	import wsg_pkg::*;
(
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// memory-mapped register port from the core
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [6:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	output logic      [15:0]           reg_rdata,
	output logic                       reg_rvalid,
	// access request from the core
	input  wire logic                  acc_req,
	input  wire wsg_space_type         acc_space,
	input  wire logic [ADDR_WIDTH-1:0] acc_addr,
	output logic                       acc_busy,
	output logic                       acc_done,
	// external bus
	input  wire logic                  ext_ready,
	output logic                       ext_strobe,
	output wsg_space_type              ext_space,
	output logic      [ADDR_WIDTH-1:0] ext_addr,
	// status
	output logic                       wait_clk_on
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [FIELD_WIDTH-1:0] field_at(
		input logic [15:0] cfg,
		input int          pos
	);
		field_at = cfg[pos +: FIELD_WIDTH];
	endfunction

	// picks the range's base count for one access
	function automatic logic [FIELD_WIDTH-1:0] select_base(
		input logic [15:0]           cfg,
		input wsg_access_type        acc
	);
		logic upper;
		upper = 1'b0;
		select_base = '0;
		case (acc.space)
			SPACE_PROG: begin
				// extended decode splits the whole space, otherwise each page
				if (cfg[POS_EXT_DECODE]) begin
					upper = acc.addr[POS_EXT_HALF];
				end else begin
					upper = acc.addr[POS_PAGE_HALF];
				end
				if (upper) begin
					select_base = field_at(cfg, POS_PROG_HIGH);
				end else begin
					select_base = field_at(cfg, POS_PROG_LOW);
				end
			end
			SPACE_DATA: begin
				if (acc.addr[POS_PAGE_HALF]) begin
					select_base = field_at(cfg, POS_DATA_HIGH);
				end else begin
					select_base = field_at(cfg, POS_DATA_LOW);
				end
			end
			SPACE_IO: begin
				select_base = field_at(cfg, POS_IO);
			end
			default: begin
				select_base = '0;
			end
		endcase
	endfunction

	// ------------------------------------------------------------
	// register requests
	// ------------------------------------------------------------
	wsg_reg_req_type reg_req;

	assign reg_req.wr    = reg_wr;
	assign reg_req.rd    = reg_rd;
	assign reg_req.addr  = reg_addr;
	assign reg_req.wdata = reg_wdata;

	// ------------------------------------------------------------
	// wait_state_config
	// ------------------------------------------------------------
	logic [15:0] wait_state_config;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wait_state_config <= CONFIG_RESET;
		end else if (reg_req.wr && reg_req.addr == ADDR_CONFIG) begin
			wait_state_config <= reg_req.wdata;
		end
	end

	// ------------------------------------------------------------
	// wait_state_multiplier_ctrl
	// ------------------------------------------------------------
	logic wait_multiplier_bit;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wait_multiplier_bit <= MULT_RESET;
		end else if (reg_req.wr && reg_req.addr == ADDR_MULT) begin
			wait_multiplier_bit <= reg_req.wdata[POS_MULT];
		end
	end

	// ------------------------------------------------------------
	// register read-back
	// ------------------------------------------------------------
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (reg_req.addr == ADDR_CONFIG) begin
			next_rdata = wait_state_config;
		end else if (reg_req.addr == ADDR_MULT) begin
			next_rdata[POS_MULT] = wait_multiplier_bit;
		end else begin
			next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// clock gate for the counter
	// ------------------------------------------------------------
	// modelled as an enable: one clock only, no gated clock net
	logic next_clk_on;

	assign next_clk_on = (wait_state_config[POS_IO+FIELD_WIDTH-1:0] != '0);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wait_clk_on <= 1'b1;
		end else begin
			wait_clk_on <= next_clk_on;
		end
	end

	// ------------------------------------------------------------
	// ready pin synchroniser
	// ------------------------------------------------------------
	logic ready_s1;
	logic ready_s2;
	logic ready_s3;
	logic ready_level;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ready_s1 <= 1'b0;
			ready_s2 <= 1'b0;
			ready_s3 <= 1'b0;
		end else begin
			ready_s1 <= ext_ready;
			ready_s2 <= ready_s1;
			ready_s3 <= ready_s2;
		end
	end

	// a change counts only once two stages agree, filtering one-cycle glitches
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ready_level <= 1'b0;
		end else if (ready_s2 == ready_s3) begin
			ready_level <= ready_s3;
		end
	end

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} wsg_state_type;

	wsg_state_type               state;
	wsg_access_type              req_acc;
	logic                        take;
	logic                        count_zero;
	logic                        finish;
	logic [FIELD_WIDTH-1:0]      base_count;
	logic [COUNT_WIDTH-1:0]      load_count;

	assign req_acc.space = acc_space;
	assign req_acc.addr  = acc_addr;
	assign take          = (state == ST_IDLE) && acc_req;
	assign base_count    = select_base(wait_state_config, req_acc);
	// up to seven doubled gives the fourteen-cycle ceiling
	assign load_count    = COUNT_WIDTH'({1'b0, base_count}) << wait_multiplier_bit;
	assign finish        = (state == ST_BUSY) && count_zero && ready_level;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						state <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (finish) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	wsg_count #(
		.WIDTH      (COUNT_WIDTH)
	) u_count (
		.core_clk   (core_clk),
		.rst_n      (rst_sync_n),
		.enable     (next_clk_on),
		.load       (take),
		.load_value (load_count),
		.count_zero (count_zero)
	);

	// ------------------------------------------------------------
	// external bus outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_strobe <= 1'b0;
			ext_space  <= SPACE_PROG;
			ext_addr   <= '0;
		end else begin
			if (take) begin
				ext_strobe <= 1'b1;
				ext_space  <= acc_space;
				ext_addr   <= acc_addr;
			end else if (finish) begin
				ext_strobe <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// core handshake outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			acc_busy <= 1'b0;
			acc_done <= 1'b0;
		end else begin
			acc_done <= finish;
			if (take) begin
				acc_busy <= 1'b1;
			end else if (finish) begin
				acc_busy <= 1'b0;
			end
		end
	end

endmodule

//--- hw/wsg_pkg.sv
package wsg_pkg;

	// ------------------------------------------------------------
	// register map (word offsets in the memory-mapped space)
	// ------------------------------------------------------------
	localparam logic [6:0]  ADDR_CONFIG      = 7'h28;
	localparam logic [6:0]  ADDR_MULT        = 7'h2a;

	// ------------------------------------------------------------
	// field layout of wait_state_config
	// ------------------------------------------------------------
	localparam int          FIELD_WIDTH      = 3;
	localparam int          POS_PROG_LOW     = 0;
	localparam int          POS_PROG_HIGH    = 3;
	localparam int          POS_DATA_LOW     = 6;
	localparam int          POS_DATA_HIGH    = 9;
	localparam int          POS_IO           = 12;
	localparam int          POS_EXT_DECODE   = 15;
	localparam int          POS_MULT         = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CONFIG_RESET     = 16'h7fff;
	localparam logic        EXT_DECODE_RESET = 1'b0;
	localparam logic        MULT_RESET       = 1'b0;

	// ------------------------------------------------------------
	// address decode points
	// ------------------------------------------------------------
	localparam int          ADDR_WIDTH       = 23;
	localparam int          POS_PAGE_HALF    = 15;
	localparam int          POS_EXT_HALF     = 22;
	localparam int          COUNT_WIDTH      = 4;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPACE_PROG,
		SPACE_DATA,
		SPACE_IO
	} wsg_space_type;

	typedef struct packed {
		wsg_space_type         space;
		logic [ADDR_WIDTH-1:0] addr;
	} wsg_access_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [15:0] wdata;
	} wsg_reg_req_type;

endpackage

//--- hw/wsg_count.sv
`timescale 1ns/1ps
module wsg_count
	import wsg_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// control
	input  wire logic             enable,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	// state
	output logic                  count_zero
);

	logic [WIDTH-1:0] count;

	// ------------------------------------------------------------
	// down-counter
	// ------------------------------------------------------------
	// with the enable low the counter is held at zero, standing in for
	// a stopped clock; a load can only ever carry zero in that state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (!enable) begin
			count <= '0;
		end else if (load) begin
			count <= load_value;
		end else if (count != '0) begin
			count <= count - WIDTH'(1);
		end
	end

	assign count_zero = (count == '0);

endmodule

//--- tb/wsg_monitor.sv
`timescale 1ns/1ps
module wsg_monitor
	import wsg_pkg::*;
(
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	// register port
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [6:0]            reg_addr,
	input wire logic [15:0]           reg_wdata,
	input wire logic [15:0]           reg_rdata,
	input wire logic                  reg_rvalid,
	// access port
	input wire logic                  acc_req,
	input wire wsg_space_type         acc_space,
	input wire logic [ADDR_WIDTH-1:0] acc_addr,
	input wire logic                  acc_busy,
	input wire logic                  acc_done,
	// external bus
	input wire logic                  ext_ready,
	input wire logic                  ext_strobe,
	input wire wsg_space_type         ext_space,
	input wire logic [ADDR_WIDTH-1:0] ext_addr,
	input wire logic                  wait_clk_on
);
	// --------------------------------
	// stretch and ready run counters
	// --------------------------------
	logic [4:0] slen;
	logic [5:0] rcnt;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			slen <= 5'h0;
		else if (!ext_strobe)
			slen <= 5'h0;
		else if (slen != 5'h1f)
			slen <= slen + 5'h1;
	end

	// saturates so a long idle cannot wrap back to a short run
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rcnt <= 6'h0;
		else if (!ext_ready)
			rcnt <= 6'h0;
		else if (rcnt != 6'h3f)
			rcnt <= rcnt + 6'h1;
	end

	AST_TAKE: assert property (acc_req && !acc_busy |=> ext_strobe && ext_addr == $past(acc_addr))
		else $error("request not taken when idle");
	AST_BUSY_STROBE: assert property (acc_busy == ext_strobe)
		else $error("busy and strobe disagree");
	AST_DONE_END: assert property (acc_done |-> $fell(ext_strobe) ##1 !acc_done)
		else $error("done not at strobe end");
	AST_HOLD_LOW: assert property ((!ext_ready [*8]) ##0 ext_strobe |=> ext_strobe)
		else $error("cycle ended while ready low");
	AST_MAX_WAIT: assert property (ext_strobe && rcnt > 6'(slen) + 6'd4 |-> slen <= 5'd14)
		else $error("stretch beyond fourteen waits");
	AST_MULT_ZERO: assert property (reg_rd && reg_addr == ADDR_MULT
		|=> reg_rvalid && reg_rdata[15:1] == 15'h0)
		else $error("control upper bits not zero");
	AST_UNMAPPED: assert property (reg_rd && reg_addr != ADDR_CONFIG && reg_addr != ADDR_MULT
		|=> reg_rdata == 16'h0)
		else $error("unmapped read not zero");
	AST_CLK_OFF: assert property (reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[14:0] == 15'h0
		|-> ##[1:2] !wait_clk_on)
		else $error("wait clock left on");
	AST_CLK_ON: assert property (reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[14:0] != 15'h0
		|-> ##[1:2] wait_clk_on)
		else $error("wait clock left off");
endmodule

bind wsg_top wsg_monitor u_mon (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rvalid, .acc_req, .acc_space, .acc_addr, .acc_busy, .acc_done,
	.ext_ready, .ext_strobe, .ext_space, .ext_addr, .wait_clk_on);

//--- tb/wsg_ext_dev.sv
`timescale 1ns/1ps
module wsg_ext_dev (
	// clock and bus
	input wire logic       core_clk,
	input wire logic       ext_strobe,
	// slowness chosen by the bench
	input wire logic [7:0] hold_off,
	output logic           ext_ready
);
	// --------------------------------
	// ready answer
	// --------------------------------
	logic [7:0] n;

	always_ff @(posedge core_clk) begin
		n <= ext_strobe ? n + 8'h01 : 8'h00;
	end

	// a fast device leaves the line high; a slow one holds it low from well
	// before its cycle, as the pin needs a few cycles to pass the synchroniser
	assign ext_ready = (hold_off == 8'h00) || (ext_strobe && n >= hold_off);
endmodule

//--- tb/wsg_top_tb.sv
`timescale 1ns/1ps
module wsg_top_tb
	import wsg_pkg::*;
;
	logic          core_clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          reg_wr = 1'b0;
	logic          reg_rd = 1'b0;
	logic [6:0]    reg_addr = 7'h00;
	logic [15:0]   reg_wdata = 16'h0000;
	logic [15:0]   reg_rdata;
	logic          reg_rvalid;
	logic          acc_req = 1'b0;
	wsg_space_type acc_space = SPACE_PROG;
	logic [22:0]   acc_addr = 23'h00_0000;
	logic          acc_busy;
	logic          acc_done;
	logic          ext_ready;
	logic          ext_strobe;
	wsg_space_type ext_space;
	logic [22:0]   ext_addr;
	logic          wait_clk_on;
	logic [7:0]    hold_off = 8'h00;
	int            fail_count = 0;
	int            checked = 0;
	int            cyc;

	wsg_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .acc_req(acc_req), .acc_space(acc_space),
		.acc_addr(acc_addr), .acc_busy(acc_busy), .acc_done(acc_done),
		.ext_ready(ext_ready), .ext_strobe(ext_strobe), .ext_space(ext_space),
		.ext_addr(ext_addr), .wait_clk_on(wait_clk_on));
	wsg_ext_dev u_dev (.core_clk(core_clk), .ext_strobe(ext_strobe), .hold_off(hold_off),
		.ext_ready(ext_ready));

	initial begin
		forever #2 core_clk = ~core_clk;
	end

	// --------------------------------
	// bus tasks
	// --------------------------------
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task close_out;
		$display("counts: %0d checked, %0d failed", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task rd(input logic [6:0] a, input logic [15:0] e);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk("rvalid", 32'(reg_rvalid), 32'h1);
		chk("rdata", 32'(reg_rdata), 32'(e));
	endtask

	// n below zero: duration judged by the caller
	task acc(input wsg_space_type s, input logic [22:0] a, input int n);
		@(negedge core_clk);
		acc_req = 1'b1;
		acc_space = s;
		acc_addr = a;
		@(negedge core_clk);
		acc_req = 1'b0;
		cyc = 0;
		while (acc_done !== 1'b1 && cyc < 200) begin
			@(negedge core_clk);
			cyc++;
		end
		if (cyc == 200) begin
			fail_count++;
			close_out();
		end else begin
			chk("ext_addr", 32'(ext_addr), 32'(a));
			chk("ext_space", 32'(ext_space), 32'(s));
			// done is seen n+1 falling edges after the one that drops the request
			if (n >= 0)
				chk("cycles", 32'(cyc), 32'(n + 1));
		end
	endtask

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		rd(ADDR_CONFIG, 16'h7fff);
		rd(ADDR_MULT, 16'h0000);
		rd(7'h29, 16'h0000);
		acc(SPACE_IO, 23'h00_ffff, 7);
		$display("test reset done");
		wr(ADDR_MULT, 16'hffff);
		rd(ADDR_MULT, 16'h0001);
		wr(ADDR_MULT, 16'h0000);
		wr(ADDR_CONFIG, 16'h58d1);
		rd(ADDR_CONFIG, 16'h58d1);
		acc(SPACE_PROG, 23'h01_0000, 1);
		acc(SPACE_PROG, 23'h41_8000, 2);
		acc(SPACE_DATA, 23'h00_7fff, 3);
		acc(SPACE_DATA, 23'h00_8000, 4);
		acc(SPACE_IO, 23'h00_0000, 5);
		wr(ADDR_CONFIG, 16'hd8d1);
		acc(SPACE_PROG, 23'h40_0000, 2);
		acc(SPACE_PROG, 23'h3f_ffff, 1);
		$display("test decode done");
		wr(ADDR_MULT, 16'h0001);
		acc(SPACE_DATA, 23'h00_8000, 8);
		wr(ADDR_CONFIG, 16'h7fff);
		acc(SPACE_IO, 23'h00_1000, 14);
		wr(ADDR_MULT, 16'h0000);
		$display("test multiplier done");
		wr(ADDR_CONFIG, 16'h8000);
		@(negedge core_clk);
		chk("wait_clk_on", 32'(wait_clk_on), 32'h0);
		acc(SPACE_DATA, 23'h00_1234, 0);
		hold_off = 8'h14;
		// let the low pin pass the synchroniser before the access starts
		repeat (6) @(negedge core_clk);
		acc(SPACE_DATA, 23'h00_4321, -1);
		chk("slow", 32'(cyc >= 22), 32'h1);
		hold_off = 8'h00;
		wr(ADDR_CONFIG, 16'h0040);
		@(negedge core_clk);
		chk("wait_clk_on", 32'(wait_clk_on), 32'h1);
		$display("test ready done");
		close_out();
	end
endmodule
